// file: logic/acf_buf.sv
`timescale 1ns/1ps
`default_nettype none
module acf_buf #(
	parameter int W = 14,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] cnt;
	} acf_buf_state_s;

	acf_buf_state_s q;
	acf_buf_state_s n;
	logic push;
	logic pop;

	assign in_ready = (q.cnt != FULL);
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rd];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb
	begin
		n = q;
		if (push)
		begin
			n.mem[q.wr] = in_data;
			n.wr = q.wr + PW'(1);
		end
		if (pop)
			n.rd = q.rd + PW'(1);
		n.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= n;
	end
endmodule : acf_buf
`default_nettype wire

// file: logic/acf_pkg.sv
// Overview of operation
// - Word is 5 address then 11 data bits
// - Sample on serial falling edge, commit every sixteenth
// - Partial trailing bits dropped; several words per select
// - One write updates all fields together
// - Standby bit powers down converter core only
// - Clock pdn tri-states clock, data unaffected
// - Software reset restores defaults, bit self-clears
// - Output pdn disables data and clock buffers
// - Clock position bit delays output clock
// - Edge bit selects receiver capture edge
// - Data position bit delays data half cycle
// - Bit-wise: even bits rising, odd falling
// - Byte-wise: low half rising, high falling
// - Zeros or ones mode forces sample bus
// - Toggle mode alternates checkerboard words
// - Ramp mode counts up, wraps to zero
// - Custom mode outputs user pattern registers
// - Format bit: zero two's complement, one binary
package acf_pkg;
	localparam int SW = 14;
	localparam int LW = 7;
	localparam int RW = 11;
	localparam int AW = 5;
	localparam int REG_N = 8;
	// Register addresses, index order of the storage array
	localparam logic [REG_N-1:0][AW-1:0] REG_ADDR = {5'h0F, 5'h0E, 5'h0C, 5'h0B,
		5'h0A, 5'h09, 5'h04, 5'h00};
	localparam logic [AW-1:0] ADDR_PWR = 5'h00;
	localparam int IDX_PWR = 0;
	localparam int IDX_TIME = 1;
	localparam int IDX_ORD = 2;
	localparam int IDX_FMT = 3;
	localparam int IDX_CLO = 4;
	localparam int IDX_CHI = 5;
	localparam logic [RW-1:0] REG_RST = 11'h000;
	// Field positions
	localparam int BIT_STBY = 0;
	localparam int BIT_PDN_CLK = 2;
	localparam int BIT_RST = 4;
	localparam int BIT_LVDS = 8;
	localparam int BIT_PDN_OBUF = 10;
	localparam int BIT_CLK_POSN = 8;
	localparam int BIT_CLK_EDGE = 9;
	localparam int BIT_DATA_POSN = 10;
	localparam int BIT_BYTEWISE = 10;
	localparam int BIT_FMT = 10;
	localparam int PAT_LSB = 5;
	localparam int PAT_MSB = 7;
	localparam int CLO_LSB = 4;
	localparam int CHI_MSB = 4;
	localparam logic [3:0] LAST_BIT = 4'hF;
	// Test pattern codes
	localparam logic [2:0] PAT_NORMAL = 3'h0;
	localparam logic [2:0] PAT_ZEROS = 3'h1;
	localparam logic [2:0] PAT_ONES = 3'h2;
	localparam logic [2:0] PAT_TOGGLE = 3'h3;
	localparam logic [2:0] PAT_RAMP = 3'h4;
	localparam logic [2:0] PAT_CUSTOM = 3'h5;
	localparam logic [SW-1:0] WORD_ZEROS = 14'h0000;
	localparam logic [SW-1:0] WORD_ONES = 14'h3FFF;
	localparam logic [SW-1:0] WORD_TOG_A = 14'h2AAA;
	localparam logic [SW-1:0] WORD_TOG_B = 14'h1555;
	localparam logic [SW-1:0] RAMP_STEP = 14'h0001;
	// Synchroniser slots
	localparam int SY_N = 5;
	localparam int SY_SCLK = 0;
	localparam int SY_SEN = 1;
	localparam int SY_SDI = 2;
	localparam int SY_CCLK = 3;
	localparam int SY_RDY = 4;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b01,
		SER_SHIFT = 2'b10
	} acf_ser_e;

	typedef struct packed {
		logic [LW-1:0] rise;
		logic [LW-1:0] fall;
	} acf_lane_s;
endpackage : acf_pkg

// file: logic/acf_top.sv
`timescale 1ns/1ps
`default_nettype none
module acf_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Serial configuration pins
	input wire logic serial_clk,
	input wire logic serial_select_n,
	input wire logic serial_in_line,
	// Conversion clock pin and converter core
	input wire logic conv_clk,
	input wire logic [11:0] core_data,
	// Receiver ready pin
	input wire logic rx_ready,
	// Sample outputs
	output logic [acf_pkg::SW-1:0] sample_bus,
	output logic [acf_pkg::LW-1:0] ddr_lanes,
	output logic sample_valid,
	output logic data_oe,
	// Output clock
	output logic output_clock_pos,
	output logic clk_oe,
	// Mode outputs
	output logic core_standby,
	output logic lvds_mode,
	output logic capture_edge_fall
);
	typedef struct packed {
		logic [acf_pkg::SY_N-1:0] sync1;
		logic [acf_pkg::SY_N-1:0] sync2;
		logic [acf_pkg::SY_N-1:0] hist;
		acf_pkg::acf_ser_e st;
		logic [3:0] cnt;
		logic [15:0] shreg;
		logic [acf_pkg::REG_N-1:0][acf_pkg::RW-1:0] regs;
		logic [acf_pkg::SW-1:0] ramp;
		logic tog;
		logic [acf_pkg::SW-1:0] bus;
		acf_pkg::acf_lane_s lanes;
		logic [acf_pkg::LW-1:0] ddr;
		logic valid;
		logic clk_out;
		logic data_oe;
		logic clk_oe;
		logic stby;
		logic lvds;
		logic cap_fall;
	} acf_state_s;

	acf_state_s q;
	acf_state_s n;
	logic sclk_fall;
	logic sen_low;
	logic cclk_rise;
	logic cclk_fall;
	logic commit;
	logic [15:0] ser_word;
	logic [2:0] pat;
	logic [acf_pkg::SW-1:0] gen_word;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [acf_pkg::SW-1:0] buf_data;
	logic upd;
	logic bytewise;
	// A net, so each generate pass may drive its own bits
	wire acf_pkg::acf_lane_s lane_w;

	////////////////////////////////////////////////////////////////////////////
	// Edge detection on second sync stage only
	assign sclk_fall = q.hist[acf_pkg::SY_SCLK] & ~q.sync2[acf_pkg::SY_SCLK];
	assign sen_low = ~q.sync2[acf_pkg::SY_SEN];
	assign cclk_rise = ~q.hist[acf_pkg::SY_CCLK] & q.sync2[acf_pkg::SY_CCLK];
	assign cclk_fall = q.hist[acf_pkg::SY_CCLK] & ~q.sync2[acf_pkg::SY_CCLK];
	assign ser_word = {q.shreg[14:0], q.sync2[acf_pkg::SY_SDI]};
	assign commit = sen_low & sclk_fall & (q.cnt == acf_pkg::LAST_BIT);
	assign pat = q.regs[acf_pkg::IDX_FMT][acf_pkg::PAT_MSB:acf_pkg::PAT_LSB];
	assign bytewise = q.regs[acf_pkg::IDX_ORD][acf_pkg::BIT_BYTEWISE];

	////////////////////////////////////////////////////////////////////////////
	// Pattern generator; unused codes give zeros
	always_comb
	begin
		case (pat)
			acf_pkg::PAT_NORMAL:
				gen_word = {core_data[11] ^ ~q.regs[acf_pkg::IDX_FMT][acf_pkg::BIT_FMT],
					core_data[10:0], 2'h0};
			acf_pkg::PAT_ZEROS: gen_word = acf_pkg::WORD_ZEROS;
			acf_pkg::PAT_ONES: gen_word = acf_pkg::WORD_ONES;
			acf_pkg::PAT_TOGGLE: gen_word = q.tog ? acf_pkg::WORD_TOG_B : acf_pkg::WORD_TOG_A;
			acf_pkg::PAT_RAMP: gen_word = q.ramp;
			acf_pkg::PAT_CUSTOM:
				gen_word = {q.regs[acf_pkg::IDX_CHI][acf_pkg::CHI_MSB:0],
					q.regs[acf_pkg::IDX_CLO][acf_pkg::RW-1:acf_pkg::CLO_LSB], 2'h0};
			default: gen_word = acf_pkg::WORD_ZEROS;
		endcase
	end

	// Generator stalls while the buffer is full, so no ramp or toggle word is lost; a normal-mode sample at that rise is dropped
	assign buf_in_valid = cclk_rise;
	assign upd = q.regs[acf_pkg::IDX_TIME][acf_pkg::BIT_DATA_POSN] ? cclk_fall : cclk_rise;
	assign buf_out_ready = upd & q.sync2[acf_pkg::SY_RDY];

	acf_buf #(
		.W(acf_pkg::SW),
		.DEPTH(2)
	) u_buf (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(gen_word),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_data)
	);

	// Lane split for double-rate output
	genvar gi;
	generate
		for (gi = 0; gi < acf_pkg::LW; gi++)
		begin : g_lane
			assign lane_w.rise[gi] = bytewise ? buf_data[gi] : buf_data[2*gi];
			assign lane_w.fall[gi] = bytewise ? buf_data[gi+acf_pkg::LW] : buf_data[2*gi+1];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n = q;
		n.sync1 = {rx_ready, conv_clk, serial_in_line, serial_select_n, serial_clk};
		n.sync2 = q.sync1;
		n.hist = q.sync2;
		// Serial word assembly
		case (q.st)
			acf_pkg::SER_IDLE: if (sen_low) n.st = acf_pkg::SER_SHIFT;
			acf_pkg::SER_SHIFT: if (!sen_low) n.st = acf_pkg::SER_IDLE;
			default: n.st = acf_pkg::SER_IDLE;
		endcase
		if (!sen_low)
			n.cnt = '0;
		else if (sclk_fall)
		begin
			n.shreg = ser_word;
			n.cnt = q.cnt + 4'h1;
		end
		// Whole register written at once; unmapped addresses ignored
		if (commit)
		begin
			for (int i = 0; i < acf_pkg::REG_N; i++)
				if (ser_word[15:11] == acf_pkg::REG_ADDR[i])
					n.regs[i] = ser_word[acf_pkg::RW-1:0];
			if (ser_word[15:11] == acf_pkg::ADDR_PWR && ser_word[acf_pkg::BIT_RST])
				n.regs = {acf_pkg::REG_N{acf_pkg::REG_RST}};
		end
		// Generator state advances only on accepted samples
		if (buf_in_valid && buf_in_ready)
		begin
			n.tog = ~q.tog;
			n.ramp = q.ramp + acf_pkg::RAMP_STEP;
		end
		// Output word update
		if (upd)
		begin
			n.valid = buf_out_valid & q.sync2[acf_pkg::SY_RDY];
			if (buf_out_valid && q.sync2[acf_pkg::SY_RDY])
			begin
				n.bus = buf_data;
				n.lanes = lane_w;
			end
		end
		if (cclk_rise)
			n.ddr = q.lanes.rise;
		else if (cclk_fall)
			n.ddr = q.lanes.fall;
		// Stand-in for the analog delay: one system cycle later
		n.clk_out = q.regs[acf_pkg::IDX_TIME][acf_pkg::BIT_CLK_POSN] ?
			q.hist[acf_pkg::SY_CCLK] : q.sync2[acf_pkg::SY_CCLK];
		n.data_oe = ~q.regs[acf_pkg::IDX_PWR][acf_pkg::BIT_PDN_OBUF];
		n.clk_oe = ~q.regs[acf_pkg::IDX_PWR][acf_pkg::BIT_PDN_OBUF] &
			~q.regs[acf_pkg::IDX_PWR][acf_pkg::BIT_PDN_CLK];
		n.stby = q.regs[acf_pkg::IDX_PWR][acf_pkg::BIT_STBY];
		n.lvds = q.regs[acf_pkg::IDX_PWR][acf_pkg::BIT_LVDS];
		n.cap_fall = q.regs[acf_pkg::IDX_TIME][acf_pkg::BIT_CLK_EDGE];
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.st <= acf_pkg::SER_IDLE;
			q.sync2 <= 5'h02;
			q.sync1 <= 5'h02;
			q.hist <= 5'h02;
			q.data_oe <= 1'b1;
			q.clk_oe <= 1'b1;
		end
		else
			q <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	assign sample_bus = q.bus;
	assign ddr_lanes = q.ddr;
	assign sample_valid = q.valid;
	assign data_oe = q.data_oe;
	assign output_clock_pos = q.clk_out;
	assign clk_oe = q.clk_oe;
	assign core_standby = q.stby;
	assign lvds_mode = q.lvds;
	assign capture_edge_fall = q.cap_fall;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_word_commit: assert property (commit && ser_word[15:11] == 5'h04 && !ser_word[4] |=>
		q.regs[acf_pkg::IDX_TIME] == $past(ser_word[10:0]))
		else $error("register word not committed");
	a_partial_discard: assert property (sen_low && q.cnt != 4'h0 ##1 !sen_low |=> q.cnt == 4'h0)
		else $error("partial word kept");
	a_unmapped_addr: assert property (commit && ser_word[15:11] inside {5'h01, 5'h1F} |=>
		$stable(q.regs))
		else $error("unmapped address changed a register");
	a_soft_reset: assert property (commit && ser_word[15:11] == 5'h00 && ser_word[4] |=>
		q.regs == '0 ##2 !core_standby && data_oe)
		else $error("software reset left state");
	a_obuf_off: assert property (q.regs[0][10] [*2] |=> !data_oe && !clk_oe)
		else $error("output buffers not disabled");
	a_clk_pdn: assert property (q.regs[0][2] && !q.regs[0][10] [*2] |=> !clk_oe && data_oe)
		else $error("clock pdn wrong");
	a_stby_follow: assert property (commit && ser_word[15:11] == 5'h00 && !ser_word[4] |=>
		##1 core_standby == $past(ser_word[0], 2))
		else $error("standby not applied");
	a_ramp_step: assert property (buf_in_valid && buf_in_ready && pat == 3'h4 |=>
		q.ramp == $past(q.ramp) + 14'h0001)
		else $error("ramp did not step");
	a_toggle_flip: assert property (buf_in_valid && buf_in_ready && pat == 3'h3 |=>
		q.tog != $past(q.tog))
		else $error("toggle did not alternate");
	a_ones_word: assert property (pat == 3'h2 |-> gen_word == 14'h3FFF)
		else $error("ones pattern wrong");
	a_byte_lanes: assert property (buf_out_ready && buf_out_valid && bytewise |=>
		q.lanes.fall == $past(buf_data[13:7]) && q.lanes.rise == $past(buf_data[6:0]))
		else $error("byte-wise lanes wrong");
	// Watches the output word itself, not the select that drives it
	a_data_edge: assert property ($changed(sample_bus) |->
		($past(q.regs[1][10]) ? $past(cclk_fall) : $past(cclk_rise)))
		else $error("data updated on wrong edge");

	c_commit: cover property (commit);
	c_soft_reset: cover property (commit && ser_word[15:11] == 5'h00 && ser_word[4]);
	c_ramp_wrap: cover property (q.ramp == 14'h3FFF && buf_in_valid && buf_in_ready);
	c_buf_stall: cover property (buf_in_valid && !buf_in_ready);
endmodule : acf_top
`default_nettype wire

// file: verification/acf_host.sv
`timescale 1ns/1ps
`default_nettype none
module acf_host (
	// Serial pins toward the device
	output logic serial_clk,
	output logic serial_select_n,
	output logic serial_in_line
);
	initial
	begin
		serial_clk = 1'b1;
		serial_select_n = 1'b1;
		serial_in_line = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// MSB first, data settles 40 ns before each falling edge
	task automatic send(input logic [31:0] bits, input int n);
		serial_select_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_in_line = bits[i];
			#40 serial_clk = 1'b0;
			#40 serial_clk = 1'b1;
		end
		#40 serial_select_n = 1'b1;
		// Released line flips, so a stale bit never looks valid
		serial_in_line = ~serial_in_line;
	endtask : send
endmodule : acf_host
`default_nettype wire

// file: verification/adc_serial_config_and_output_format_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_and_output_format_bench;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic conv_clk = 1'b0;
	logic rx_ready = 1'b1;
	logic [11:0] core_data = 12'h000;
	logic serial_clk, serial_select_n, serial_in_line;
	logic [13:0] sample_bus;
	logic [6:0] ddr_lanes;
	logic sample_valid, data_oe, output_clock_pos, clk_oe;
	logic core_standby, lvds_mode, capture_edge_fall;
	logic [10:0] rg [32];
	logic [13:0] a, b;
	logic [2:0] pl [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
	int c0, c1;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	integer seed = 54461;
	always #5 sys_clk = ~sys_clk;
	initial #13 forever #40 conv_clk = ~conv_clk;
	acf_host host (.serial_clk(serial_clk), .serial_select_n(serial_select_n),
		.serial_in_line(serial_in_line));
	acf_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
		.serial_select_n(serial_select_n), .serial_in_line(serial_in_line),
		.conv_clk(conv_clk), .core_data(core_data), .rx_ready(rx_ready),
		.sample_bus(sample_bus), .ddr_lanes(ddr_lanes), .sample_valid(sample_valid),
		.data_oe(data_oe), .output_clock_pos(output_clock_pos), .clk_oe(clk_oe),
		.core_standby(core_standby), .lvds_mode(lvds_mode),
		.capture_edge_fall(capture_edge_fall));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	// Unmapped addresses land in spare model slots and are never read
	task automatic wr(input logic [4:0] ad, input logic [10:0] d, input int x = 0);
		host.send({11'h000, ad, d, 5'h1F} >> (5 - x), 16 + x);
		if (ad == 5'h00 && d[4])
			foreach (rg[i]) rg[i] = 11'h000;
		else
			rg[ad] = d;
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : wr
	task automatic modes();
		chk("data_oe", {13'h0, ~rg[0][10]}, {13'h0, data_oe});
		chk("clk_oe", {13'h0, ~rg[0][10] & ~rg[0][2]}, {13'h0, clk_oe});
		chk("standby", {13'h0, rg[0][0]}, {13'h0, core_standby});
		chk("lvds", {13'h0, rg[0][8]}, {13'h0, lvds_mode});
		chk("edge", {13'h0, rg[4][9]}, {13'h0, capture_edge_fall});
	endtask : modes
	// One word per update edge; it stands from three cycles after it
	task automatic nxt(output logic [13:0] w);
		if (rg[4][10])
			@(negedge conv_clk);
		else
			@(posedge conv_clk);
		repeat (4) @(posedge sys_clk);
		#1;
		w = sample_bus;
		chk("sample_valid", 14'h1, {13'h0, sample_valid});
	endtask : nxt
	// Old words still sit in the buffer after a mode change
	task automatic flush();
		repeat (3) nxt(b);
	endtask : flush
	// Cycles from a conversion clock rise to the output clock rise
	task automatic clkpos(output int c);
		@(posedge conv_clk);
		c = 0;
		while (output_clock_pos !== 1'b1 && c < 20)
		begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask : clkpos
	function automatic logic [13:0] ew(input logic [11:0] c);
		case (rg[10][7:5])
			3'h0: return {c[11] ^ ~rg[10][10], c[10:0], 2'b00};
			3'h2: return 14'h3FFF;
			3'h5: return {rg[12][4:0], rg[11][10:4], 2'b00};
			default: return 14'h0000;
		endcase
	endfunction : ew
	function automatic logic [6:0] ln(input logic [13:0] w, input logic f);
		for (int i = 0; i < 7; i++)
			ln[i] = rg[9][10] ? w[7 * f + i] : w[2 * i + f];
	endfunction : ln
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		foreach (rg[i]) rg[i] = 11'h000;
		repeat (10) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		modes();
		clkpos(c0);
		for (int i = 0; i < 4; i++)
		begin
			wr(5'h0A, {i[0], 10'h000});
			core_data = 12'($random(seed));
			flush();
			nxt(a);
			chk("normal", ew(core_data), a);
		end
		foreach (rg[i]) if (i < 8) rg[i] = 11'h000;
		wr(5'h0B, {7'($random(seed)), 4'h0});
		wr(5'h0C, {6'h00, 5'($random(seed))});
		foreach (pl[k])
		begin
			wr(5'h0A, {3'h0, pl[k], 5'h00});
			flush();
			nxt(a);
			chk("pattern", ew(core_data), a);
		end
		wr(5'h0A, {3'h0, 3'h5, 5'h00});
		wr(5'h00, 11'h100);
		for (int m = 0; m < 2; m++)
		begin
			wr(5'h09, {m[0], 10'h000});
			flush();
			// Look inside the half period that each lane set stands for
			@(posedge conv_clk);
			repeat (4) @(posedge sys_clk);
			#1;
			chk("rise", {7'h0, ln(ew(core_data), 1'b0)}, {7'h0, ddr_lanes});
			@(negedge conv_clk);
			repeat (4) @(posedge sys_clk);
			#1;
			chk("fall", {7'h0, ln(ew(core_data), 1'b1)}, {7'h0, ddr_lanes});
		end
		wr(5'h0A, {3'h0, 3'h3, 5'h00});
		flush();
		nxt(a);
		nxt(b);
		chk("toggle", 14'h3FFF, a ^ b);
		chk("toggle_a", (a === 14'h2AAA) ? 14'h2AAA : 14'h1555, a);
		// Random stalls fill the buffer; no ramp code may go missing
		wr(5'h0A, {3'h0, 3'h4, 5'h00});
		flush();
		nxt(a);
		for (int k = 0; k < 12; k++)
		begin
			rx_ready = 1'($random(seed));
			// Only a stall may hold words back; a free run goes on at once
			if (!rx_ready)
			begin
				repeat (30) @(posedge sys_clk);
				#1 rx_ready = 1'b1;
			end
			nxt(b);
			chk("ramp", a + 14'h0001, b);
			a = b;
		end
		// Trailing partial bits and an unmapped address change nothing
		wr(5'h00, 11'h101, 5);
		modes();
		wr(5'h01, 11'h404);
		modes();
		wr(5'h00, 11'h004);
		modes();
		wr(5'h00, 11'h400);
		modes();
		wr(5'h04, 11'h700);
		modes();
		clkpos(c1);
		chk("clk_posn", 14'h0001, 14'(c1 - c0));
		// Word must still be old just after the fall and new soon after it
		@(negedge conv_clk);
		@(posedge sys_clk);
		#1 a = sample_bus;
		repeat (3) @(posedge sys_clk);
		#1 b = sample_bus;
		chk("data_posn", a + 14'h0001, b);
		wr(5'h00, 11'h015);
		modes();
		conclude();
	end
endmodule : adc_serial_config_and_output_format_bench
`default_nettype wire
